// File: design/adcc_pkg.sv
// constants and carrier types of the converter command interpreter
package adcc_pkg;
   localparam int        REG_COUNT = 11;
   localparam logic [3:0] ADDR_LAST = 4'ha;
   localparam logic [3:0] A_STATUS  = 4'h0;
   localparam logic [3:0] A_ADCON   = 4'h2;
   localparam logic [3:0] A_DRATE   = 4'h3;
   localparam logic [3:0] A_OFC0    = 4'h5;
   localparam logic [3:0] A_FSC0    = 4'h8;
   localparam logic [7:0] RST_STATUS = 8'h01;
   localparam logic [7:0] RST_MUX    = 8'h01;
   localparam logic [7:0] RST_ADCON  = 8'h20;
   localparam logic [7:0] RST_DRATE  = 8'hf0;
   localparam logic [7:0] RST_IO     = 8'he0;
   localparam logic [7:0] RST_CORR   = 8'h00;
   localparam logic [7:0] ADCON_CLK_MASK = 8'h60;
   localparam int B_ORDER = 3;
   localparam int B_AUTO_CAL_ENABLE  = 2;
   localparam int B_INPUT_BUFFER_ENABLE = 1;
   localparam logic [7:0] OP_WAKE0  = 8'h00;
   localparam logic [7:0] OP_RDATA  = 8'h01;
   localparam logic [7:0] OP_STREAM = 8'h03;
   localparam logic [7:0] OP_STOP   = 8'h0f;
   localparam logic [3:0] OP_REGISTER_BURST_READ   = 4'h1;
   localparam logic [3:0] OP_REGISTER_BURST_WRITE   = 4'h5;
   localparam logic [7:0] OP_CAL_LO = 8'hf0;
   localparam logic [7:0] OP_CAL_HI = 8'hf4;
   localparam logic [7:0] OP_SYNC   = 8'hfc;
   localparam logic [7:0] OP_STBY   = 8'hfd;
   localparam logic [7:0] OP_RESET  = 8'hfe;
   localparam logic [7:0] OP_WAKE1  = 8'hff;
   localparam logic [2:0] CAL_BOTH  = 3'h0;
   localparam logic [2:0] CAL_OFF   = 3'h1;
   localparam logic [2:0] CAL_GAIN  = 3'h2;
   localparam logic [2:0] CAL_SOFF  = 3'h3;
   localparam logic [2:0] CAL_SGAIN = 3'h4;
   localparam int RES_W = 24;
   localparam logic [23:0] RES_MAX = 24'h7fffff;
   localparam logic [23:0] RES_MIN = 24'h800000;

   typedef struct packed {
      logic       bit_order;
      logic       auto_cal_enable;
      logic       input_buffer_enable;
      logic [2:0] gain_select;
      logic [7:0] rate_select;
   } adcc_cfg_t;

   typedef struct packed {
      logic [23:0] offset_correction;
      logic [23:0] fullscale_correction;
   } adcc_corr_t;
endpackage

// File: design/adcc_core.sv
// serial command interpreter of a 24-bit delta-sigma converter
// Summary of operation
// - results leave as 24-bit two's complement words
// - out-of-range results clamp to 7fffff/800000
// - command and data bytes may follow back to back
// - 00h/ffh wake: finish sync, leave standby
// - 01h single read, 03h stream, 0fh stop
// - 1r/5r register read/write, second byte count
// - f0h..f4h launch the five calibrations
// - fch sync, fdh standby, feh restore defaults of registers 0-4, ADCON clock bits kept
// - bit-order setting controls returned bit sequence
// - order 0 msb first, 1 lsb first
// - ready rises after all 24 bits out
// - stream mode presents each new result unasked
// - stop or reset byte ends stream mode
// - register read bursts count plus one, wrapping
// - register write stores count plus one bytes
// - auto-cal on gain, rate or buffer change
// - combined cal updates offset and fullscale
// - offset cal leaves fullscale unchanged
// - ready high during calibration, low after
// - ready falls when a new result arrives
// - sample on falling, shift on rising edge
`timescale 1ns/1ns
module adcc_core #(
   parameter int         RAW_W   = 26,
   parameter logic [3:0] ID_BITS = 4'h5 // arbitrary value
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             cs_n,
   input  wire logic             sclk,
   input  wire logic             din,
   output logic                  dout,
   output logic                  dout_oe,
   output logic                  conversion_ready_n,
   input  wire logic             result_valid,
   input  wire logic [RAW_W-1:0] result_raw,
   output logic                  cal_start,
   output logic [2:0]            cal_kind,
   input  wire logic             cal_done,
   input  wire adcc_pkg::adcc_corr_t cal_value,
   output logic                  sync_pulse,
   output logic                  standby,
   output adcc_pkg::adcc_cfg_t   cfg,
   output adcc_pkg::adcc_corr_t  corr
);
   if (RAW_W < adcc_pkg::RES_W) begin : g_chk
      $error("result_raw narrower than a result word");
   end

   typedef enum logic [2:0] {
      ST_CMD, ST_CNT, ST_WDATA, ST_RDATA, ST_RESULT, ST_CAL
   } adcc_state_t;

   function automatic logic [3:0] next_addr(input logic [3:0] a);
      next_addr = (a >= adcc_pkg::ADDR_LAST) ? 4'h0 : a + 4'h1;
   endfunction

   function automatic logic [23:0] sat(input logic [RAW_W-1:0] r);
      logic signed [RAW_W-1:0] s;
      s = signed'(r);
      if (s > signed'(RAW_W'(adcc_pkg::RES_MAX)))
         sat = adcc_pkg::RES_MAX;
      else if (s <= -signed'(RAW_W'(adcc_pkg::RES_MAX)) - 1)
         sat = adcc_pkg::RES_MIN;
      else
         sat = r[23:0];
   endfunction

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detection
   logic [2:0] sclk_s_q;
   logic [1:0] cs_s_q;
   logic [1:0] din_s_q;
   logic       sclk_fall;
   logic       sclk_rise;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sclk_s_q <= 3'h0;
         cs_s_q   <= 2'h3;
         din_s_q  <= 2'h0;
      end else begin
         sclk_s_q <= {sclk_s_q[1:0], sclk};
         cs_s_q   <= {cs_s_q[0], cs_n};
         din_s_q  <= {din_s_q[0], din};
      end
   end
   assign sclk_fall = sclk_s_q[2] & ~sclk_s_q[1] & ~cs_s_q[1];
   assign sclk_rise = ~sclk_s_q[2] & sclk_s_q[1] & ~cs_s_q[1];

   ////////////////////////////////////////////////////////////////////
   // command engine
   adcc_state_t st_q, st_d;
   logic [7:0]  regs_q [adcc_pkg::REG_COUNT];
   logic [7:0]  regs_d [adcc_pkg::REG_COUNT];
   logic [6:0]  rx_q, rx_d;
   logic [2:0]  bit_q, bit_d;
   logic [7:0]  tx_q, tx_d;
   logic        dout_q, dout_d;
   logic [3:0]  addr_q, addr_d;
   logic [3:0]  cnt_q, cnt_d;
   logic        wr_q, wr_d;
   logic        chg_q, chg_d;
   logic [1:0]  idx_q, idx_d;
   logic [23:0] res_q, res_d;
   logic        rdy_n_q, rdy_n_d;
   logic        stream_q, stream_d;
   logic        cal_q, cal_d;
   logic [2:0]  kind_q, kind_d;
   logic        pend_q, pend_d;
   logic        sync_q, sync_d;
   logic        stby_q, stby_d;
   logic        byte_done;
   logic [7:0]  rx_byte;
   logic [2:0]  out_bit;

   assign byte_done = sclk_fall && bit_q == 3'h7;
   assign rx_byte   = {rx_q, din_s_q[1]};
   // bit order applies within the byte only
   assign out_bit = regs_q[adcc_pkg::A_STATUS][adcc_pkg::B_ORDER]
                  ? bit_q : 3'h7 - bit_q;

   function automatic logic [7:0] rd_reg(input logic [3:0] a,
                                        input logic       rdy);
      if (a == adcc_pkg::A_STATUS)
         rd_reg = {ID_BITS, regs_q[0][3:1], rdy};
      else if (a > adcc_pkg::ADDR_LAST)
         rd_reg = 8'h00;
      else
         rd_reg = regs_q[a];
   endfunction

   always_comb begin
      st_d = st_q;
      regs_d = regs_q;
      rx_d = rx_q;
      bit_d = bit_q;
      tx_d = tx_q;
      dout_d = dout_q;
      addr_d = addr_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      chg_d = chg_q;
      idx_d = idx_q;
      res_d = res_q;
      rdy_n_d = rdy_n_q;
      stream_d = stream_q;
      cal_d = 1'b0;
      kind_d = kind_q;
      pend_d = pend_q;
      sync_d = 1'b0;
      stby_d = stby_q;
      if (result_valid && st_q != ST_CAL) begin
         res_d = sat(result_raw);
         rdy_n_d = 1'b0;
         if (stream_q && st_q == ST_CMD) begin
            st_d = ST_RESULT;
            idx_d = 2'h0;
            tx_d = res_d[23:16];
         end
      end
      if (sclk_rise)
         dout_d = tx_q[out_bit];
      if (sclk_fall) begin
         rx_d = rx_byte[6:0];
         bit_d = bit_q + 3'h1;
      end
      if (byte_done) begin
         case (st_q)
            ST_CMD: begin
               if (rx_byte == adcc_pkg::OP_WAKE0 ||
                   rx_byte == adcc_pkg::OP_WAKE1) begin
                  sync_d = pend_q;
                  pend_d = 1'b0;
                  stby_d = 1'b0;
               end else if (rx_byte == adcc_pkg::OP_RDATA) begin
                  st_d = ST_RESULT;
                  idx_d = 2'h0;
                  tx_d = res_q[23:16];
               end else if (rx_byte == adcc_pkg::OP_STREAM)
                  stream_d = 1'b1;
               else if (rx_byte == adcc_pkg::OP_STOP)
                  stream_d = 1'b0;
               else if (rx_byte[7:4] == adcc_pkg::OP_REGISTER_BURST_READ ||
                        rx_byte[7:4] == adcc_pkg::OP_REGISTER_BURST_WRITE) begin
                  st_d = ST_CNT;
                  wr_d = rx_byte[6];
                  addr_d = rx_byte[3:0];
                  chg_d = 1'b0;
               end else if (rx_byte >= adcc_pkg::OP_CAL_LO &&
                            rx_byte <= adcc_pkg::OP_CAL_HI) begin
                  st_d = ST_CAL;
                  cal_d = 1'b1;
                  kind_d = rx_byte[2:0];
                  rdy_n_d = 1'b1;
               end else if (rx_byte == adcc_pkg::OP_SYNC) begin
                  pend_d = 1'b1;
                  rdy_n_d = 1'b1;
               end else if (rx_byte == adcc_pkg::OP_STBY)
                  stby_d = 1'b1;
               else if (rx_byte == adcc_pkg::OP_RESET) begin
                  stream_d = 1'b0;
                  regs_d[0] = adcc_pkg::RST_STATUS;
                  regs_d[1] = adcc_pkg::RST_MUX;
                  regs_d[2] = (adcc_pkg::RST_ADCON
                              & ~adcc_pkg::ADCON_CLK_MASK)
                              | (regs_q[2] & adcc_pkg::ADCON_CLK_MASK);
                  regs_d[3] = adcc_pkg::RST_DRATE;
                  regs_d[4] = adcc_pkg::RST_IO;
               end
            end
            ST_CNT: begin
               cnt_d = rx_byte[3:0];
               st_d = wr_q ? ST_WDATA : ST_RDATA;
               tx_d = rd_reg(addr_q, rdy_n_q);
            end
            ST_RDATA: begin
               addr_d = next_addr(addr_q);
               tx_d = rd_reg(addr_d, rdy_n_q);
               cnt_d = cnt_q - 4'h1;
               if (cnt_q == 4'h0)
                  st_d = ST_CMD;
            end
            ST_WDATA: begin
               if (addr_q <= adcc_pkg::ADDR_LAST) begin
                  regs_d[addr_q] = rx_byte;
                  if ((addr_q == adcc_pkg::A_STATUS &&
                       rx_byte[adcc_pkg::B_INPUT_BUFFER_ENABLE] !=
                       regs_q[0][adcc_pkg::B_INPUT_BUFFER_ENABLE]) ||
                      (addr_q == adcc_pkg::A_ADCON &&
                       rx_byte[2:0] != regs_q[2][2:0]) ||
                      (addr_q == adcc_pkg::A_DRATE &&
                       rx_byte != regs_q[3]))
                     chg_d = 1'b1;
                  if (addr_q == adcc_pkg::A_STATUS)
                     regs_d[0][0] = regs_q[0][0];
               end
               addr_d = next_addr(addr_q);
               cnt_d = cnt_q - 4'h1;
               if (cnt_q == 4'h0) begin
                  st_d = ST_CMD;
                  if (chg_d && regs_d[0][adcc_pkg::B_AUTO_CAL_ENABLE]) begin
                     st_d = ST_CAL;
                     cal_d = 1'b1;
                     kind_d = adcc_pkg::CAL_BOTH;
                     rdy_n_d = 1'b1;
                  end
               end
            end
            ST_RESULT: begin
               idx_d = idx_q + 2'h1;
               tx_d = (idx_q == 2'h0) ? res_q[15:8] : res_q[7:0];
               if (idx_q == 2'h2) begin
                  rdy_n_d = 1'b1;
                  st_d = ST_CMD;
               end
               if (stream_q && (rx_byte == adcc_pkg::OP_STOP ||
                                rx_byte == adcc_pkg::OP_RESET))
                  stream_d = 1'b0;
            end
            default: st_d = st_q;
         endcase
      end
      if (st_q == ST_CAL && cal_done) begin
         st_d = ST_CMD;
         rdy_n_d = 1'b0;
         if (kind_q != adcc_pkg::CAL_GAIN &&
             kind_q != adcc_pkg::CAL_SGAIN)
            for (int i = 0; i < 3; i++)
               regs_d[4'(int'(adcc_pkg::A_OFC0) + i)] =
                  cal_value.offset_correction[8*i +: 8];
         if (kind_q == adcc_pkg::CAL_BOTH ||
             kind_q == adcc_pkg::CAL_GAIN ||
             kind_q == adcc_pkg::CAL_SGAIN)
            for (int i = 0; i < 3; i++)
               regs_d[4'(int'(adcc_pkg::A_FSC0) + i)] =
                  cal_value.fullscale_correction[8*i +: 8];
      end
      // deselect resets the serial interface
      if (cs_s_q[1]) begin
         bit_d = 3'h0;
         if (st_q != ST_CAL)
            st_d = ST_CMD;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_q <= ST_CMD;
         regs_q <= '{adcc_pkg::RST_STATUS, adcc_pkg::RST_MUX,
                     adcc_pkg::RST_ADCON, adcc_pkg::RST_DRATE,
                     adcc_pkg::RST_IO, adcc_pkg::RST_CORR,
                     adcc_pkg::RST_CORR, adcc_pkg::RST_CORR,
                     adcc_pkg::RST_CORR, adcc_pkg::RST_CORR,
                     adcc_pkg::RST_CORR};
         rx_q <= 7'h0;
         bit_q <= 3'h0;
         tx_q <= 8'h0;
         dout_q <= 1'b0;
         addr_q <= 4'h0;
         cnt_q <= 4'h0;
         wr_q <= 1'b0;
         chg_q <= 1'b0;
         idx_q <= 2'h0;
         res_q <= 24'h0;
         rdy_n_q <= 1'b1;
         stream_q <= 1'b0;
         cal_q <= 1'b0;
         kind_q <= 3'h0;
         pend_q <= 1'b0;
         sync_q <= 1'b0;
         stby_q <= 1'b0;
      end else begin
         st_q <= st_d;
         regs_q <= regs_d;
         rx_q <= rx_d;
         bit_q <= bit_d;
         tx_q <= tx_d;
         dout_q <= dout_d;
         addr_q <= addr_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         chg_q <= chg_d;
         idx_q <= idx_d;
         res_q <= res_d;
         rdy_n_q <= rdy_n_d;
         stream_q <= stream_d;
         cal_q <= cal_d;
         kind_q <= kind_d;
         pend_q <= pend_d;
         sync_q <= sync_d;
         stby_q <= stby_d;
      end
   end

   assign dout = dout_q;
   assign dout_oe = ~cs_s_q[1] & (st_q == ST_RDATA || st_q == ST_RESULT);
   assign conversion_ready_n = rdy_n_q;
   assign cal_start = cal_q;
   assign cal_kind = kind_q;
   assign sync_pulse = sync_q;
   assign standby = stby_q;
   assign cfg = '{bit_order: regs_q[0][adcc_pkg::B_ORDER],
                  auto_cal_enable: regs_q[0][adcc_pkg::B_AUTO_CAL_ENABLE],
                  input_buffer_enable: regs_q[0][adcc_pkg::B_INPUT_BUFFER_ENABLE],
                  gain_select: regs_q[2][2:0],
                  rate_select: regs_q[3]};
   assign corr = '{offset_correction: {regs_q[7], regs_q[6], regs_q[5]},
                   fullscale_correction: {regs_q[10], regs_q[9],
                                          regs_q[8]}};

   ////////////////////////////////////////////////////////////////////
   // assertions
   property p_sat_pos;
      @(posedge clk) disable iff (!reset_n)
      result_valid && st_q != ST_CAL &&
      $signed(result_raw) > $signed(RAW_W'(adcc_pkg::RES_MAX))
      |=> res_q == adcc_pkg::RES_MAX;
   endproperty
   a_sat_pos: assert property (p_sat_pos)
      else $error("positive overrange not clamped");

   property p_rdy_fall;
      @(posedge clk) disable iff (!reset_n)
      result_valid && st_q != ST_CAL |=> !conversion_ready_n;
   endproperty
   a_rdy_fall: assert property (p_rdy_fall)
      else $error("ready did not fall on new result");

   property p_rdy_rise;
      @(posedge clk) disable iff (!reset_n)
      byte_done && st_q == ST_RESULT && idx_q == 2'h2 && !result_valid
      |=> conversion_ready_n && st_q == ST_CMD;
   endproperty
   a_rdy_rise: assert property (p_rdy_rise)
      else $error("ready not high after third byte");

   property p_cal_start;
      @(posedge clk) disable iff (!reset_n)
      byte_done && st_q == ST_CMD && rx_byte == adcc_pkg::OP_CAL_LO
      |=> cal_start && conversion_ready_n && cal_kind == 3'h0
          ##1 !cal_start;
   endproperty
   a_cal_start: assert property (p_cal_start)
      else $error("calibration launch wrong");

   property p_cal_keep_fs;
      @(posedge clk) disable iff (!reset_n)
      st_q == ST_CAL && cal_done && kind_q == adcc_pkg::CAL_OFF
      |=> corr.offset_correction == $past(cal_value.offset_correction)
          && $stable(corr.fullscale_correction);
   endproperty
   a_cal_keep_fs: assert property (p_cal_keep_fs)
      else $error("offset cal touched fullscale");

   property p_cal_both;
      @(posedge clk) disable iff (!reset_n)
      st_q == ST_CAL && cal_done && kind_q == adcc_pkg::CAL_BOTH
      |=> corr == $past(cal_value) && !conversion_ready_n;
   endproperty
   a_cal_both: assert property (p_cal_both)
      else $error("combined cal did not load both");

   property p_stream_stop;
      @(posedge clk) disable iff (!reset_n)
      byte_done && st_q == ST_RESULT && rx_byte == adcc_pkg::OP_STOP
      |=> !stream_q;
   endproperty
   a_stream_stop: assert property (p_stream_stop)
      else $error("stop byte did not end stream");

   property p_wrap;
      @(posedge clk) disable iff (!reset_n)
      byte_done && st_q == ST_RDATA && addr_q == adcc_pkg::ADDR_LAST
      |=> addr_q == 4'h0;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("read burst did not wrap");

   c_single: cover property (@(posedge clk) disable iff (!reset_n)
      st_q == ST_RESULT ##[1:1000] st_q == ST_CMD);
   c_cal: cover property (@(posedge clk) disable iff (!reset_n)
      cal_start ##[1:1000] cal_done);
   c_stream: cover property (@(posedge clk) disable iff (!reset_n)
      stream_q && result_valid);
endmodule

// File: tb/adcc_host.sv
// serial host model that drives the converter link
`timescale 1ns/1ns
module adcc_host (
   output logic       cs_n,
   output logic       sclk,
   output logic       din,
   input  wire logic  dout,
   output logic [7:0] rx_byte
);
   event rx_ev;

   initial begin
      cs_n    = 1'b1;
      sclk    = 1'b0;
      din     = 1'b0;
      rx_byte = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // select stays low for the whole sequence; the odd start delay keeps
   // the link out of phase with the block clock
   task automatic frame(input logic on);
      #83;
      cs_n = !on;
      din  = !din;
      #80;
   endtask

   // bytes follow back to back; din moves on the rise, dout is read
   // half way through the low phase
   task automatic xfer(input logic [7:0] tx);
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'b1;
         din  = tx[i];
         #40;
         sclk = 1'b0;
         #20;
         rx_byte[i] = dout;
         #20;
      end
      -> rx_ev;
   endtask
endmodule

// File: tb/adcc_core_bench.sv
// self-checking bench of the converter command interpreter
`timescale 1ns/1ns
module adcc_core_bench;
   typedef struct packed {
      logic       care;
      logic [7:0] val;
   } adcc_note_t;
   localparam logic [3:0] ID = 4'h5; // arbitrary identification value
   logic                 clk, reset_n, cs_n, sclk, din, dout, dout_oe;
   logic                 conversion_ready_n, result_valid, cal_done;
   logic                 cal_start, sync_pulse, standby, order;
   logic                 cal_seen, sync_seen;
   logic [2:0]           cal_kind, kind_seen;
   logic [25:0]          result_raw, r;
   logic [23:0]          e;
   logic [7:0]           rx;
   logic [7:0]           regs [11];
   adcc_pkg::adcc_corr_t cal_value, corr, cexp;
   adcc_pkg::adcc_cfg_t  cfg;
   adcc_note_t           exp_q [$];
   int                   fails = 0;
   int                   check_count = 0;
   int                   seed = 67;

   adcc_core #(.ID_BITS(ID)) dut_u (
      .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .din(din),
      .dout(dout), .dout_oe(dout_oe),
      .conversion_ready_n(conversion_ready_n),
      .result_valid(result_valid), .result_raw(result_raw),
      .cal_start(cal_start), .cal_kind(cal_kind), .cal_done(cal_done),
      .cal_value(cal_value), .sync_pulse(sync_pulse), .standby(standby),
      .cfg(cfg), .corr(corr));
   adcc_host host_u (
      .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .rx_byte(rx));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // pulse catchers, cleared by the main sequence before each command that should raise a pulse
   always @(posedge clk) begin
      if (cal_start === 1'b1) begin
         cal_seen  <= 1'b1;
         kind_seen <= cal_kind;
      end
      if (sync_pulse === 1'b1) begin
         sync_seen <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   function automatic logic [7:0] rev(input logic [7:0] b);
      for (int i = 0; i < 8; i++) rev[i] = b[7 - i];
   endfunction

   function automatic logic [23:0] sat(input logic [25:0] v);
      if ($signed(v) > $signed(26'h07fffff)) return adcc_pkg::RES_MAX;
      if ($signed(v) < $signed(26'h3800000)) return adcc_pkg::RES_MIN;
      return v[23:0];
   endfunction

   function automatic logic [25:0] rnd();
      logic [23:0] x;
      x = 24'($random(seed));
      return {{2{x[23]}}, x};
   endfunction

   // the reader takes the oldest note as each byte arrives
   initial begin
      adcc_note_t n;
      forever begin
         @(host_u.rx_ev);
         n = exp_q.pop_front();
         if (n.care) check(rx, n.val);
      end
   end

   task automatic sb(input logic [7:0] tx, input logic c, input logic [7:0] v);
      exp_q.push_back('{c, order ? rev(v) : v});
      host_u.xfer(tx);
   endtask

   task automatic wait_for(input logic sel);
      int n;
      n = 0;
      while (!(sel ? sync_seen : cal_seen) && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) begin
         fails++;
         $display("Error at %0t: wait ran out", $time);
         print_verdict();
      end
   endtask

   task automatic give_result(input logic [25:0] raw);
      @(negedge clk);
      result_raw   = raw;
      result_valid = 1'b1;
      @(negedge clk);
      result_valid = 1'b0;
      @(negedge clk);
      check(conversion_ready_n, 1'b0);
   endtask

   task automatic cmd(input logic [7:0] op);
      host_u.frame(1'b1);
      sb(op, 1'b0, 8'h00);
      host_u.frame(1'b0);
   endtask

   task automatic read_one(input logic [25:0] raw, input logic [7:0] idle);
      logic [23:0] x;
      x = sat(raw);
      give_result(raw);
      host_u.frame(1'b1);
      sb(8'h01, 1'b0, 8'h00);
      check(dout_oe, 1'b1);
      sb(idle, 1'b1, x[23:16]);
      sb(idle, 1'b1, x[15:8]);
      sb(idle, 1'b1, x[7:0]);
      host_u.frame(1'b0);
      check({conversion_ready_n, dout_oe}, 2'b10);
      regs[0][0] = 1'b1;
   endtask

   task automatic register_burst_read(input logic [3:0] a, input logic [3:0] n);
      host_u.frame(1'b1);
      sb({4'h1, a}, 1'b0, 8'h00);
      sb({4'h0, n}, 1'b0, 8'h00);
      for (int i = 0; i <= n; i++) begin
         sb(8'hff, 1'b1, a == 4'h0 ? {ID, regs[0][3:0]} : regs[a]);
         a = (a == adcc_pkg::ADDR_LAST) ? 4'h0 : a + 4'h1;
      end
      host_u.frame(1'b0);
   endtask

   task automatic register_burst_write(input logic [3:0] a, input logic [3:0] n,
                       input logic [7:0] v);
      logic [7:0] d;
      host_u.frame(1'b1);
      sb({4'h5, a}, 1'b0, 8'h00);
      sb({4'h0, n}, 1'b0, 8'h00);
      for (int i = 0; i <= n; i++) begin
         d = (n == 4'h0) ? v : 8'($random(seed));
         if (a == adcc_pkg::A_ADCON) d[7] = 1'b0;
         if (a == 4'h0) d[0] = regs[0][0];
         regs[a] = d;
         sb(d, 1'b0, 8'h00);
         a = (a == adcc_pkg::ADDR_LAST) ? 4'h0 : a + 4'h1;
      end
      host_u.frame(1'b0);
   endtask

   task automatic cal_run(input logic [2:0] k);
      adcc_pkg::adcc_corr_t cv;
      wait_for(1'b0);
      check(kind_seen, k);
      check(conversion_ready_n, 1'b1);
      cv.offset_correction    = 24'($random(seed));
      cv.fullscale_correction = 24'($random(seed));
      if (k != 3'h2 && k != 3'h4) cexp.offset_correction = cv.offset_correction;
      if (k != 3'h1 && k != 3'h3)
         cexp.fullscale_correction = cv.fullscale_correction;
      @(negedge clk);
      cal_value = cv;
      cal_done  = 1'b1;
      @(negedge clk);
      cal_done  = 1'b0;
      @(negedge clk);
      check(corr, cexp);
      check(conversion_ready_n, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [25:0] raws [6];
      raws = '{26'h0, 26'h1, 26'h3ffffff, 26'h0800000, 26'h3800000,
               26'h3000000};
      regs = '{8'h01, 8'h01, 8'h20, 8'hf0, 8'he0, 8'h00, 8'h00, 8'h00,
               8'h00, 8'h00, 8'h00};
      reset_n = 1'b0;
      result_valid = 1'b0;
      result_raw = 26'h0;
      cal_done = 1'b0;
      cal_value = '0;
      order = 1'b0;
      cal_seen = 1'b0;
      sync_seen = 1'b0;
      kind_seen = 3'h0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      check({conversion_ready_n, standby, dout_oe, corr},
            {3'b100, 48'h0});
      register_burst_read(4'h3, 4'ha);
      $display("reset and wrap read finished");
      register_burst_write(4'h5, 4'h5, 8'h00);
      register_burst_write(4'h2, 4'h1, 8'h00);
      register_burst_read(4'h8, 4'h5);
      cexp = {regs[7], regs[6], regs[5], regs[10], regs[9], regs[8]};
      check(corr, cexp);
      check({cfg.gain_select, cfg.rate_select},
            {regs[2][2:0], regs[3]});
      $display("register bursts finished");
      for (int i = 0; i < 7; i++) begin
         read_one(i < 6 ? raws[i] : rnd(), i[0] ? 8'hff : 8'h00);
      end
      register_burst_write(4'h0, 4'h0, 8'h08);
      order = 1'b1;
      read_one(rnd(), 8'h00);
      register_burst_read(4'h0, 4'h1);
      register_burst_write(4'h0, 4'h0, 8'h00);
      order = 1'b0;
      $display("single reads finished");
      give_result(rnd());
      host_u.frame(1'b1);
      sb(8'h03, 1'b0, 8'h00);
      // stream mode waits for the next result before it shifts anything
      for (int k = 0; k < 3; k++) begin
         r = rnd();
         give_result(r);
         e = sat(r);
         sb(8'h00, 1'b1, e[23:16]);
         sb(k == 2 ? 8'h0f : 8'hff, 1'b1, e[15:8]);
         sb(8'h00, 1'b1, e[7:0]);
      end
      give_result(rnd());
      check(dout_oe, 1'b0);
      host_u.frame(1'b0);
      register_burst_read(4'h1, 4'h0);
      $display("stream finished");
      for (int k = 0; k < 5; k++) begin
         give_result(rnd());
         cal_seen = 1'b0;
         cmd(8'hf0 + 8'(k));
         cal_run(3'(k));
      end
      register_burst_write(4'h0, 4'h0, 8'h04);
      cal_seen = 1'b0;
      register_burst_write(4'h3, 4'h0, ~regs[3]);
      cal_run(3'h0);
      $display("calibration finished");
      cmd(8'hfd);
      check(standby, 1'b1);
      cmd(8'hff);
      check(standby, 1'b0);
      sync_seen = 1'b0;
      host_u.frame(1'b1);
      sb(8'hfc, 1'b0, 8'h00);
      sb(8'h00, 1'b0, 8'h00);
      host_u.frame(1'b0);
      wait_for(1'b1);
      cmd(8'hfe);
      check(cfg, {3'b000, 3'h0, 8'hf0});
      $display("mode commands finished");
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      check({conversion_ready_n, standby, dout_oe, corr},
            {3'b100, 48'h0});
      read_one(rnd(), 8'hff);
      $display("mid-run reset finished");
      print_verdict();
   end
endmodule
